/* memory_map_decoder_test.sv */
// testbench for the memory map decoder: ahb-lite tasks and cpu probes
// assumes mmd_top, mmd_cpu_model and the bound checker
`include "mmd_consts.svh"
module memory_map_decoder_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [3:0] T_NO = 4'h0, T_REG = 4'h8, T_RAM = 4'h4, T_EE = 4'h2, T_ROM = 4'h1;
   localparam logic [31:0] A_EE = {22'h0, `MMD_IDX_EE_MAP, 2'h0};
   localparam logic [31:0] A_MAP = {22'h0, `MMD_IDX_RAM_MAP, 2'h0};
   localparam logic [31:0] A_CFG = {22'h0, `MMD_IDX_SYS_CFG, 2'h0};
   localparam logic [31:0] A_STAT = {22'h0, `MMD_IDX_STATUS, 2'h0};
   logic clk, rst_b, mode_smod, mode_mda, hsel, hwrite, hreadyout, hresp, cpu_valid;
   logic req_valid, sel_reg, sel_ram, sel_ee, sel_rom;
   logic [31:0] haddr, hwdata, hrdata, r;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [15:0] cpu_addr, req_addr;
   logic [14:0] sel_offset;
   wire hready = hreadyout;
   int n_fail, n_compared, cyc;
   mmd_top u_mmd_top
   (
      .clk(clk),
      .rst_b(rst_b),
      .mode_smod(mode_smod),
      .mode_mda(mode_mda),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .cpu_addr(cpu_addr),
      .cpu_valid(cpu_valid),
      .sel_reg(sel_reg),
      .sel_ram(sel_ram),
      .sel_ee(sel_ee),
      .sel_rom(sel_rom),
      .sel_offset(sel_offset)
   );
   mmd_cpu_model u_mmd_cpu_model
   (
      .clk(clk),
      .req_addr(req_addr),
      .req_valid(req_valid),
      .cpu_addr(cpu_addr),
      .cpu_valid(cpu_valid)
   );
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // ======================================
   // tasks
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task results;
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // one single word transfer; read data taken at the edge ending the data phase
   task xfer(input logic w, input logic [31:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask
   task wr(input logic [31:0] a, input logic [7:0] d);
      xfer(1'b1, a, d);
   endtask
   task rdc(input logic [31:0] a, input logic [7:0] e);
      xfer(1'b0, a, 8'h0);
      chk(r, {24'h0, e});
   endtask
   // model takes the address at the next edge, decode shows one edge later;
   // looked at mid-cycle while it stands, then back on a rising edge
   task p(input logic [15:0] a, input logic [3:0] t, input logic [14:0] o);
      req_addr <= a;
      req_valid <= 1'b1;
      @(posedge clk);
      req_valid <= 1'b0;
      @(posedge clk);
      @(negedge clk);
      chk({13'h0, sel_reg, sel_ram, sel_ee, sel_rom, sel_offset}, {13'h0, t, o});
      @(posedge clk);
   endtask
   task rst(input logic s, input logic m);
      rst_b <= 1'b0;
      mode_smod <= s;
      mode_mda <= m;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
   endtask
   // hang guard
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_fail++;
         results();
      end
   end
   // ======================================
   // main sequence: expanded, special test, single chip
   initial
   begin
      hsel = 1'b0;
      htrans = 2'h0;
      haddr = 32'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
      req_addr = 16'h0;
      req_valid = 1'b0;
      rst(1'b0, 1'b1);
      rdc(A_STAT, 8'h09);
      rdc(A_CFG, `MMD_SYS_CFG_RST);
      rdc(A_MAP, 8'h00);
      rdc(32'h0000_0200, 8'h00);
      p(16'h0000, T_REG, 15'h0);
      p(16'h007F, T_REG, 15'h007F);
      p(16'h0080, T_RAM, 15'h0080);
      p(16'h02FF, T_RAM, 15'h02FF);
      p(16'h0300, T_RAM, 15'h0);
      p(16'h037F, T_RAM, 15'h007F);
      p(16'h0380, T_NO, 15'h0);
      p(16'hFFFF, T_ROM, 15'h5FFF);
      wr(A_MAP, 8'h10);
      rdc(A_MAP, 8'h10);
      p(16'h1000, T_RAM, 15'h0);
      p(16'h12FF, T_RAM, 15'h02FF);
      p(16'h0080, T_EE, 15'h0080);
      p(16'h1300, T_NO, 15'h0);
      wr(A_MAP, 8'h04);
      rdc(A_MAP, 8'h10);
      rst(1'b1, 1'b1);
      rdc(A_CFG, 8'hC1);
      p(16'hA000, T_NO, 15'h0);
      repeat (70) @(posedge clk);
      wr(A_MAP, 8'h04);
      rdc(A_MAP, 8'h04);
      rdc(A_STAT, 8'h07);
      p(16'h4000, T_REG, 15'h0);
      p(16'h407F, T_REG, 15'h007F);
      p(16'h0000, T_RAM, 15'h0);
      p(16'h0300, T_NO, 15'h0);
      wr(A_CFG, 8'h43);
      p(16'h2000, T_ROM, 15'h0);
      rst(1'b0, 1'b0);
      wr(A_EE, 8'h5F);
      rdc(A_EE, 8'h50);
      wr(A_CFG, 8'h01);
      rdc(A_CFG, 8'h41);
      p(16'hA000, T_ROM, 15'h0);
      p(16'h2000, T_NO, 15'h0);
      p(16'h527F, T_EE, 15'h027F);
      p(16'h5280, T_NO, 15'h0);
      repeat (70) @(posedge clk);
      wr(A_MAP, 8'h10);
      rdc(A_MAP, 8'h00);
      rdc(A_STAT, 8'h00);
      results();
   end
endmodule

/* mmd_asserts.sv */
// checker for the memory map decoder, watching the top ports only
// assumes one clock domain and straps steady after reset
`include "mmd_consts.svh"
module mmd_checker
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mode_smod,
   input wire logic mode_mda,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_valid,
   input wire logic sel_reg,
   input wire logic sel_ram,
   input wire logic sel_ee,
   input wire logic sel_rom,
   input wire logic [14:0] sel_offset
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire [3:0] sel_v = {sel_reg, sel_ram, sel_ee, sel_rom};
   wire [14:0] off = sel_offset;
   // ======================================
   // properties
   property p_reset;
      disable iff (1'b0) !rst_b |=> sel_v == 4'h0 && off == 15'h0 && hrdata == 32'h0;
   endproperty
   property p_onehot; $onehot0(sel_v); endproperty
   property p_okay; hresp == 1'b0; endproperty
   property p_ready; hreadyout == 1'b1; endproperty
   property p_rdata; hrdata[31:8] == 24'h0; endproperty
   property p_idle; !cpu_valid |=> sel_v == 4'h0 && off == 15'h0; endproperty
   // register block is 128-byte aligned, so its offset is the low address bits
   property p_reg_off; cpu_valid ##1 sel_reg |-> off == {8'h0, $past(cpu_addr[6:0])}; endproperty
   property p_sizes;
      (!sel_ram || off < 15'h0300) && (!sel_ee || off < 15'h0280)
      && (!sel_reg || off < 15'h0080) && (!sel_rom || off < 15'h6000);
   endproperty
   // vector space must never fall through in single chip
   property p_single;
      !mode_smod && !mode_mda && cpu_valid && cpu_addr >= 16'hA000 |=> sel_v != 4'h0;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs not cleared by reset");
   a_onehot: assert property (p_onehot) else $error("two targets at once");
   a_okay: assert property (p_okay) else $error("bus response not okay");
   a_ready: assert property (p_ready) else $error("bus ready low");
   a_rdata: assert property (p_rdata) else $error("read data upper bits set");
   a_idle: assert property (p_idle) else $error("target without valid access");
   a_reg_off: assert property (p_reg_off) else $error("register offset wrong");
   a_sizes: assert property (p_sizes) else $error("offset beyond region size");
   a_single: assert property (p_single) else $error("vector space unmapped");
   c_reg: cover property (sel_reg);
   c_ee: cover property (sel_ee);
   c_rom: cover property (sel_rom);
   c_ram: cover property (sel_ram);
endmodule
bind mmd_top mmd_checker u_mmd_checker
(
   .clk(clk),
   .rst_b(rst_b),
   .mode_smod(mode_smod),
   .mode_mda(mode_mda),
   .hreadyout(hreadyout),
   .hresp(hresp),
   .hrdata(hrdata),
   .cpu_addr(cpu_addr),
   .cpu_valid(cpu_valid),
   .sel_reg(sel_reg),
   .sel_ram(sel_ram),
   .sel_ee(sel_ee),
   .sel_rom(sel_rom),
   .sel_offset(sel_offset)
);

/* mmd_consts.svh */
// constants of the memory map decoder: register offsets, field positions,
// reset values, region sizes and timing counts
// assumes a 16-bit cpu address space and a 32-bit ahb-lite register bus
`ifndef MMD_CONSTS_SVH
`define MMD_CONSTS_SVH

// ======================================================
// register indices (byte address is four times the index)
`define MMD_IDX_EE_MAP 8'h37
`define MMD_IDX_RAM_MAP 8'h3D
`define MMD_IDX_SYS_CFG 8'h3F
`define MMD_IDX_STATUS 8'h40

// ======================================================
// field positions
`define MMD_CFG_ROM_HI 7
`define MMD_CFG_FIXED1 6
`define MMD_CFG_ROM_EN 1
`define MMD_CFG_EEON 0
// writable configuration bits; the rest always read their reset value
`define MMD_CFG_WMASK 8'h83
// special test leaves reset with the rom enable bit cleared
`define MMD_CFG_TEST_CLR 8'hFD

// ======================================================
// reset values
`define MMD_RAM_MAP_RST 8'h00
`define MMD_EE_MAP_RST 8'h00
`define MMD_SYS_CFG_RST 8'hC3

// ======================================================
// region geometry
`define MMD_REG_SIZE 16'h0080
`define MMD_RAM_SIZE 16'h0300
`define MMD_RAM_MOVED 16'h0080
`define MMD_EE_SIZE 16'h0280
`define MMD_ROM_SIZE 16'h6000
`define MMD_ROM_HI_BASE 16'hA000
`define MMD_ROM_LO_BASE 16'h2000

// ======================================================
// timing: cpu cycles after reset in which the ram/register map may be set
`define MMD_MAP_WINDOW_CYCLES 7'd64
`endif

/* mmd_cpu_model.sv */
// cpu core model: presents one address per request to the decoder
// assumes the bench raises requests just after a rising edge
module mmd_cpu_model
(
   input wire logic clk,
   input wire logic [15:0] req_addr,
   input wire logic req_valid,
   output logic [15:0] cpu_addr,
   output logic cpu_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   initial cpu_addr = 16'h5A5A;
   initial cpu_valid = 1'b0;
   // idle bus toggles so a stale address can never look valid by luck
   always @(posedge clk)
   begin
      cpu_valid <= req_valid;
      cpu_addr <= req_valid ? req_addr : ~cpu_addr;
   end
endmodule

/* mmd_decode.sv */
// combinational address decoder: one cpu address in, one target and offset out
// assumes effective rom enable and placement are already resolved by the caller
`include "mmd_consts.svh"

module mmd_decode
(
   input wire logic [15:0] addr,
   input wire logic [3:0] ram_nib,
   input wire logic [3:0] reg_nib,
   input wire logic [3:0] ee_nib,
   input wire logic ee_on,
   input wire logic rom_on,
   input wire logic rom_hi,
   output mmd_pkg::mmd_target_t target,
   output logic [14:0] offset
);
   // ======================================================
   // region bases
   wire logic [15:0] reg_base = {reg_nib, 12'h000};
   wire logic [15:0] ram_base = {ram_nib, 12'h000};
   wire logic [15:0] ee_base = {ee_nib, 12'h000};
   wire logic [15:0] rom_base = rom_hi ? `MMD_ROM_HI_BASE : `MMD_ROM_LO_BASE;
   wire logic [15:0] reg_off = addr - reg_base;
   wire logic [15:0] ram_off = addr - ram_base;
   wire logic [15:0] ee_off = addr - ee_base;
   wire logic [15:0] rom_off = addr - rom_base;

   // ======================================================
   // hits; the wrap of the subtraction keeps addresses below a base out
   wire logic hit_reg = reg_off < `MMD_REG_SIZE;
   // registers sharing the ram page hide its first bytes, which move up
   wire logic overlap = ram_nib == reg_nib;
   wire logic hit_ram_main = ram_off < `MMD_RAM_SIZE;
   wire logic hit_ram_moved = overlap && ram_off >= `MMD_RAM_SIZE
      && ram_off < (`MMD_RAM_SIZE + `MMD_RAM_MOVED);
   wire logic hit_ee = ee_on && ee_off < `MMD_EE_SIZE;
   wire logic hit_rom = rom_on && rom_off < `MMD_ROM_SIZE;

   // single target per access: registers, then ram, then eeprom, then rom
   always_comb
   begin
      target = mmd_pkg::MMD_TGT_NONE;
      offset = 15'h0000;
      if (hit_reg)
      begin
         target = mmd_pkg::MMD_TGT_REG;
         offset = reg_off[14:0];
      end
      else if (hit_ram_main)
      begin
         target = mmd_pkg::MMD_TGT_RAM;
         offset = ram_off[14:0];
      end
      else if (hit_ram_moved)
      begin
         target = mmd_pkg::MMD_TGT_RAM;
         offset = 15'(ram_off - `MMD_RAM_SIZE);
      end
      else if (hit_ee)
      begin
         target = mmd_pkg::MMD_TGT_EE;
         offset = ee_off[14:0];
      end
      else if (hit_rom)
      begin
         target = mmd_pkg::MMD_TGT_ROM;
         offset = rom_off[14:0];
      end
   end
endmodule

/* mmd_pkg.sv */
// types shared by the memory map decoder files
// assumes nothing beyond the constants header
package mmd_pkg;
   // target of one cpu access, in priority order
   typedef enum logic [2:0]
   {
      MMD_TGT_NONE = 3'b000,
      MMD_TGT_REG = 3'b001,
      MMD_TGT_RAM = 3'b010,
      MMD_TGT_EE = 3'b011,
      MMD_TGT_ROM = 3'b100
   } mmd_target_t;
endpackage

/* mmd_top.sv */
// memory map decoder: placement registers on ahb-lite and the cpu address decode
// assumes the cpu address is synchronous to clk and that the mode straps are
// stable while rst_b is low
`include "mmd_consts.svh"

module mmd_top
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic mode_smod,
   input wire logic mode_mda,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_valid,
   output logic sel_reg,
   output logic sel_ram,
   output logic sel_ee,
   output logic sel_rom,
   output logic [14:0] sel_offset
);
   // ======================================================
   // operating mode, caught while reset is held
   logic smod_r;
   logic mda_r;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         smod_r <= mode_smod;
         mda_r <= mode_mda;
      end
   end
   wire logic single_chip = !smod_r && !mda_r;
   wire logic special_test = smod_r && mda_r;

   // ======================================================
   // ahb-lite address phase capture
   logic wr_pend_r;
   logic [7:0] wr_idx_r;
   wire logic acc = hsel && htrans[1] && hready;
   wire logic [7:0] a_idx = haddr[9:2];
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         wr_pend_r <= 1'b0;
         wr_idx_r <= 8'h00;
      end
      else
      begin
         wr_pend_r <= acc && hwrite && hsize == 3'b010;
         wr_idx_r <= a_idx;
      end
   end

   // ======================================================
   // write window counter for the ram/register map
   logic [6:0] win_cnt_r;
   logic map_written_r;
   wire logic win_open = win_cnt_r < `MMD_MAP_WINDOW_CYCLES;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
         win_cnt_r <= 7'd0;
      else if (win_open)
         win_cnt_r <= win_cnt_r + 7'd1;
   end

   // ======================================================
   // write decode; special modes may rewrite the map at any time
   wire logic wr_ram_map = wr_pend_r && wr_idx_r == `MMD_IDX_RAM_MAP;
   wire logic wr_ee_map = wr_pend_r && wr_idx_r == `MMD_IDX_EE_MAP;
   wire logic wr_sys_cfg = wr_pend_r && wr_idx_r == `MMD_IDX_SYS_CFG;
   wire logic map_ok = smod_r || (win_open && !map_written_r);

   logic [7:0] ram_map_r;
   logic [7:0] ee_map_r;
   logic [7:0] sys_cfg_r;
   wire logic [7:0] cfg_wmask = `MMD_CFG_WMASK;
   wire logic [7:0] cfg_rst = special_test
      ? (`MMD_SYS_CFG_RST & `MMD_CFG_TEST_CLR) : `MMD_SYS_CFG_RST;
   // one merge of written and fixed bits, shared by the register and the read path
   wire logic [7:0] cfg_wval = (hwdata[7:0] & cfg_wmask) | (`MMD_SYS_CFG_RST & ~cfg_wmask);

   // placement registers; outside special modes the map refuses late or second writes silently
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         ram_map_r <= `MMD_RAM_MAP_RST;
         map_written_r <= 1'b0;
         ee_map_r <= `MMD_EE_MAP_RST;
         sys_cfg_r <= `MMD_SYS_CFG_RST;
      end
      else
      begin
         if (wr_ram_map && map_ok)
         begin
            ram_map_r <= hwdata[7:0];
            map_written_r <= 1'b1;
         end
         if (wr_ee_map)
            ee_map_r <= {hwdata[7:4], 4'h0};
         if (wr_sys_cfg)
            sys_cfg_r <= cfg_wval;
      end
   end

   // special test leaves reset with the rom enable cleared
   logic cfg_loaded_r;
   logic rom_on_r;
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         cfg_loaded_r <= 1'b0;
         rom_on_r <= 1'b0;
      end
      else
      begin
         cfg_loaded_r <= 1'b1;
         if (wr_sys_cfg)
            rom_on_r <= hwdata[`MMD_CFG_ROM_EN];
         else if (!cfg_loaded_r)
            rom_on_r <= cfg_rst[`MMD_CFG_ROM_EN];
      end
   end

   // effective rom placement: single chip overrides the stored bits
   wire logic rom_on_eff = single_chip || rom_on_r;
   wire logic rom_hi_eff = single_chip || sys_cfg_r[`MMD_CFG_ROM_HI];
   wire logic [7:0] cfg_view = {sys_cfg_r[7:2], rom_on_r, sys_cfg_r[0]};

   // ======================================================
   // read data, with a pending write forwarded so a back-to-back read sees it
   wire logic [7:0] ram_map_v = (wr_ram_map && map_ok) ? hwdata[7:0] : ram_map_r;
   wire logic [7:0] ee_map_v = wr_ee_map ? {hwdata[7:4], 4'h0} : ee_map_r;
   wire logic [7:0] cfg_v = wr_sys_cfg ? cfg_wval : cfg_view;
   wire logic [7:0] status_v = {4'h0, win_open, map_written_r, smod_r, mda_r};
   logic [7:0] rd_sel;
   always_comb
   begin
      if (a_idx == `MMD_IDX_RAM_MAP)
         rd_sel = ram_map_v;
      else if (a_idx == `MMD_IDX_EE_MAP)
         rd_sel = ee_map_v;
      else if (a_idx == `MMD_IDX_SYS_CFG)
         rd_sel = cfg_v;
      else if (a_idx == `MMD_IDX_STATUS)
         rd_sel = status_v;
      else
         rd_sel = 8'h00; // unmapped words read zero
   end

   // zero wait state slave; always okay
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (acc && !hwrite)
            hrdata <= {24'h00_0000, rd_sel};
      end
   end

   // ======================================================
   // cpu address decode from the three configuration registers, the stored rom enable and the single chip mode
   mmd_pkg::mmd_target_t tgt;
   logic [14:0] tgt_off;
   mmd_decode u_decode
   (
      .addr(cpu_addr),
      .ram_nib(ram_map_r[7:4]),
      .reg_nib(ram_map_r[3:0]),
      .ee_nib(ee_map_r[7:4]),
      .ee_on(sys_cfg_r[`MMD_CFG_EEON]),
      .rom_on(rom_on_eff),
      .rom_hi(rom_hi_eff),
      .target(tgt),
      .offset(tgt_off)
   );

   // registered selects, one cycle after the address
   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         sel_reg <= 1'b0;
         sel_ram <= 1'b0;
         sel_ee <= 1'b0;
         sel_rom <= 1'b0;
         sel_offset <= 15'h0000;
      end
      else
      begin
         sel_reg <= cpu_valid && tgt == mmd_pkg::MMD_TGT_REG;
         sel_ram <= cpu_valid && tgt == mmd_pkg::MMD_TGT_RAM;
         sel_ee <= cpu_valid && tgt == mmd_pkg::MMD_TGT_EE;
         sel_rom <= cpu_valid && tgt == mmd_pkg::MMD_TGT_ROM;
         sel_offset <= cpu_valid ? tgt_off : 15'h0000;
      end
   end
endmodule
